// file: design/acl_map.svh
// Register offsets, field positions, reset values and timing figures of the block.
// Assumes it is included by the control block and the bench, and the clock runs at 250 MHz.
`ifndef ACL_MAP_SVH
`define ACL_MAP_SVH

`define ACL_ADDR_STATUS  7'h00
`define ACL_ADDR_OUT_XL  7'h04
`define ACL_ADDR_OUT_XH  7'h05
`define ACL_ADDR_OUT_YL  7'h06
`define ACL_ADDR_OUT_YH  7'h07
`define ACL_ADDR_OUT_ZL  7'h08
`define ACL_ADDR_OUT_ZH  7'h09
`define ACL_ADDR_VECTOR_MAGNITUDE_REGS_L  7'h0a
`define ACL_ADDR_VECTOR_MAGNITUDE_REGS_H  7'h0b
`define ACL_ADDR_BUF_XL  7'h0c
`define ACL_ADDR_BUF_XH  7'h0d
`define ACL_ADDR_BUF_YL  7'h0e
`define ACL_ADDR_BUF_YH  7'h0f
`define ACL_ADDR_BUF_ZL  7'h10
`define ACL_ADDR_BUF_ZH  7'h11
`define ACL_ADDR_CFG1    7'h15
`define ACL_ADDR_ODR     7'h16
`define ACL_ADDR_INT_EN  7'h20
`define ACL_ADDR_PIN_SEL 7'h21
`define ACL_ADDR_INT_DRV 7'h22
`define ACL_ADDR_SELFTEST_IDLE_CODE 7'h37
`define ACL_ADDR_SELFTEST_DECIMATION_CODE  7'h38

`define ACL_DRDY_BIT     7
`define ACL_RST_BIT      7
`define ACL_AXIS_RANGE   6:5
`define ACL_PWR_RANGE    1:0
`define ACL_ODR_RANGE    3:0
`define ACL_BOOTDIS_BIT  0
`define ACL_BOOTPIN_BIT  7
`define ACL_OD_BIT       0
`define ACL_IDLE_RANGE   4:0
`define ACL_DEC_RANGE    3:0
`define ACL_AX_LO        7:0
`define ACL_AX_HI        11:8

`define ACL_RST_BYTE     8'h00
`define ACL_DEC_MAX      4'hc
`define ACL_PM_LOW       2'h0
`define ACL_ODR_ST       4'h0
`define ACL_SYNC_RST     5'h01

`define ACL_CLK_NS       4
`define ACL_ST_BASE_NS   312500
`define ACL_ST_STEP_NS   31250
`define ACL_BOOT_WAIT_NS 1000000
`define ACL_BOOT_PLS_NS  50000

`endif

// file: design/acl_pkg.sv
// Types shared by the control block, its link module and the bench.
// Assumes nothing of its surroundings.
package acl_pkg;
  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } acl_axes_s;
  typedef struct packed {
    acl_axes_s   axes;
    logic [11:0] vector_magnitude_regs;
  } acl_sample_s;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } acl_wr_s;
  typedef enum logic [1:0] {BOOT_WAIT, BOOT_PULSE, BOOT_IDLE} acl_boot_e;
endpackage : acl_pkg

// file: design/acl_shadow.sv
// Output data register with shadow copy held back while a read is locked.
// Assumes lock is already synchronised to core_clk.
module acl_shadow #(
  parameter int unsigned W = 48
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         lock,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              upd
);
  logic [W-1:0] shadow;
  logic         pend;

  if (W == 0) begin : g_bad
    $error("acl_shadow width must be nonzero");
  end

  assign upd = !lock && (in_valid || pend);

  always_ff @(posedge core_clk) begin
    if (rst) dout <= '0;
    else if (upd) dout <= in_valid ? din : shadow;
  end

  always_ff @(posedge core_clk) begin
    if (rst) shadow <= '0;
    else if (lock && in_valid) shadow <= din;
  end

  always_ff @(posedge core_clk) begin
    if (rst) pend <= 1'b0;
    else if (lock && in_valid) pend <= 1'b1;
    else if (!lock) pend <= 1'b0;
  end

  a_frozen_lock: assert property (@(posedge core_clk) disable iff (rst)
    lock |=> $stable(dout)) else $error("data changed while locked");

  a_release_load: assert property (@(posedge core_clk) disable iff (rst)
    (lock && in_valid) ##1 (!lock && !in_valid) |=> dout == $past(din, 2))
    else $error("shadow not shown after release");
endmodule : acl_shadow

// file: design/acl_link.sv
// Serial register port on the link clock: command byte, then data bytes.
// Assumes the link clock runs only while chip select is low.
module acl_link (
  input  wire logic          link_clk,
  input  wire logic          sys_rst,
  input  wire logic          spi_cs_n,
  input  wire logic          spi_mosi,
  output logic               spi_miso,
  output logic               spi_miso_oe_n,
  output logic         [6:0] rd_addr,
  input  wire logic    [7:0] rd_data,
  output acl_pkg::acl_wr_s   wr,
  output logic               wr_tgl
);
  logic [2:0] bit_cnt;
  logic [6:0] rx;
  logic [7:0] tx;
  logic       in_data;
  logic       is_rd;
  logic       byte_end;

  assign byte_end      = bit_cnt == 3'h7;
  assign spi_miso      = tx[7];
  assign spi_miso_oe_n = !(!spi_cs_n && in_data && is_rd);

  always_ff @(posedge link_clk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      bit_cnt <= 3'h0;
      rx      <= 7'h00;
      in_data <= 1'b0;
      is_rd   <= 1'b0;
      rd_addr <= 7'h00;
    end else begin
      rx      <= {rx[5:0], spi_mosi};
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end && !in_data) begin
        in_data <= 1'b1;
        is_rd   <= rx[6];
        rd_addr <= {rx[5:0], spi_mosi};
      end else if (byte_end) begin
        rd_addr <= rd_addr + 7'h01;
      end
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr     <= '0;
      wr_tgl <= 1'b0;
    end else if (!spi_cs_n && in_data && !is_rd && byte_end) begin
      wr     <= '{addr: rd_addr, data: {rx, spi_mosi}};
      wr_tgl <= !wr_tgl;
    end
  end

  always_ff @(negedge link_clk or posedge spi_cs_n) begin
    if (spi_cs_n) tx <= 8'h00;
    else if (in_data && is_rd && bit_cnt == 3'h0) tx <= rd_data;
    else tx <= {tx[6:0], 1'b0};
  end
endmodule : acl_link

// file: design/acl_ctrl.sv
// Self-test timing, read-coherent data registers, boot and pin signalling.
// Assumes samples arrive on core_clk and the host link runs on its own clock.
`include "acl_map.svh"

module acl_ctrl import acl_pkg::*; #(
  parameter int unsigned CLK_NS       = `ACL_CLK_NS,
  parameter int unsigned ST_BASE_NS   = `ACL_ST_BASE_NS,
  parameter int unsigned ST_STEP_NS   = `ACL_ST_STEP_NS,
  parameter int unsigned BOOT_WAIT_NS = `ACL_BOOT_WAIT_NS,
  parameter int unsigned BOOT_PLS_NS  = `ACL_BOOT_PLS_NS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe_n,
  input  wire logic        sample_valid,
  input  acl_sample_s      sample,
  input  wire logic        buff_valid,
  input  acl_axes_s        buff,
  input  wire logic        external_trigger_in_pin,
  input  wire logic        md_pin_in,
  input  wire logic        strap_pin,
  input  wire logic        motion_event,
  input  wire logic        irq_a_req,
  input  wire logic        irq_b_req,
  output logic             irq_a_out,
  output logic             irq_a_oe_n,
  output logic             irq_b_out,
  output logic             irq_b_oe_n,
  output logic             md_out,
  output logic             md_oe_n,
  output logic             host_pm_req,
  output logic             single_shot,
  output logic             wake_req,
  output logic             selftest_active,
  output logic             st_meas_strobe,
  output logic       [3:0] meas_odr,
  output logic       [1:0] meas_power_mode,
  output logic             load_motion_defaults,
  output logic             boot_done
);
  localparam int unsigned BOOT_WAIT_CYC = (BOOT_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BOOT_PLS_CYC  = (BOOT_PLS_NS + CLK_NS - 1) / CLK_NS;

  if (CLK_NS == 0 || BOOT_WAIT_CYC == 0 || BOOT_PLS_CYC == 0 || ST_BASE_NS < CLK_NS)
  begin : g_bad
    $error("acl_ctrl timing parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Host link and pin synchronisers.

  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;
  acl_wr_s     wr;
  logic        wr_tgl;
  logic [4:0]  async_in;
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        cs_d;
  logic        trig_d;
  logic        wt_d;
  logic        lock;
  logic        wr_fire;
  logic        soft_rst;
  logic        rst_int;

  acl_link u_link (
    .link_clk      (link_clk),
    .sys_rst       (sys_rst),
    .spi_cs_n      (spi_cs_n),
    .spi_mosi      (spi_mosi),
    .spi_miso      (spi_miso),
    .spi_miso_oe_n (spi_miso_oe_n),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .wr            (wr),
    .wr_tgl        (wr_tgl)
  );

  assign async_in = {wr_tgl, strap_pin, md_pin_in, external_trigger_in_pin, spi_cs_n};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    localparam logic [4:0] SRST = `ACL_SYNC_RST;
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        sync1[i] <= SRST[i];
        sync2[i] <= SRST[i];
      end else begin
        sync1[i] <= async_in[i];
        sync2[i] <= sync1[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_d   <= 1'b1;
      trig_d <= 1'b0;
      wt_d   <= 1'b0;
    end else begin
      cs_d   <= sync2[0];
      trig_d <= sync2[1];
      wt_d   <= sync2[4];
    end
  end

  assign lock    = !sync2[0];
  assign wr_fire = sync2[4] ^ wt_d;
  assign rst_int = sys_rst || soft_rst;

  always_ff @(posedge core_clk) begin
    if (sys_rst) soft_rst <= 1'b0;
    else soft_rst <= wr_fire && wr.addr == `ACL_ADDR_CFG1 && wr.data[`ACL_RST_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [1:0] axis_sel;
  logic [1:0] pwr_mode;
  logic [3:0] odr;
  logic       boot_pulse_disable;
  logic       pin_sel;
  logic       od_sel;
  logic [4:0] selftest_idle_code;
  logic [3:0] selftest_decimation_code;
  logic [7:0] rst_b;

  assign rst_b = `ACL_RST_BYTE;

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      axis_sel <= rst_b[`ACL_AXIS_RANGE];
      pwr_mode <= rst_b[`ACL_PWR_RANGE];
      odr      <= rst_b[`ACL_ODR_RANGE];
      boot_pulse_disable <= rst_b[`ACL_BOOTDIS_BIT];
      pin_sel  <= rst_b[`ACL_BOOTPIN_BIT];
      od_sel   <= rst_b[`ACL_OD_BIT];
      selftest_idle_code  <= rst_b[`ACL_IDLE_RANGE];
      selftest_decimation_code   <= rst_b[`ACL_DEC_RANGE];
    end else if (wr_fire) begin
      case (wr.addr)
        `ACL_ADDR_CFG1: begin
          axis_sel <= wr.data[`ACL_AXIS_RANGE];
          pwr_mode <= wr.data[`ACL_PWR_RANGE];
        end
        `ACL_ADDR_ODR:     odr      <= wr.data[`ACL_ODR_RANGE];
        `ACL_ADDR_INT_EN:  boot_pulse_disable <= wr.data[`ACL_BOOTDIS_BIT];
        `ACL_ADDR_PIN_SEL: pin_sel  <= wr.data[`ACL_BOOTPIN_BIT];
        `ACL_ADDR_INT_DRV: od_sel   <= wr.data[`ACL_OD_BIT];
        `ACL_ADDR_SELFTEST_IDLE_CODE: selftest_idle_code  <= wr.data[`ACL_IDLE_RANGE];
        `ACL_ADDR_SELFTEST_DECIMATION_CODE:  selftest_decimation_code   <= wr.data[`ACL_DEC_RANGE];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coherent output data.

  acl_sample_s smp_q;
  acl_axes_s   buf_q;
  logic        smp_upd;
  logic        buf_upd;
  logic        drdy;

  acl_shadow #(.W($bits(acl_sample_s))) u_smp (
    .core_clk (core_clk),
    .rst      (rst_int),
    .lock     (lock),
    .in_valid (sample_valid),
    .din      (sample),
    .dout     (smp_q),
    .upd      (smp_upd)
  );

  acl_shadow #(.W($bits(acl_axes_s))) u_buf (
    .core_clk (core_clk),
    .rst      (rst_int),
    .lock     (lock),
    .in_valid (buff_valid),
    .din      (buff),
    .dout     (buf_q),
    .upd      (buf_upd)
  );

  always_ff @(posedge core_clk) begin
    if (rst_int) drdy <= 1'b0;
    else if (smp_upd) drdy <= 1'b1;
    else if (sync2[0] && !cs_d) drdy <= 1'b0;
  end

  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      `ACL_ADDR_STATUS:  rd_data[`ACL_DRDY_BIT] = drdy;
      `ACL_ADDR_OUT_XL:  rd_data = smp_q.axes.x[`ACL_AX_LO];
      `ACL_ADDR_OUT_XH:  rd_data = {4'h0, smp_q.axes.x[`ACL_AX_HI]};
      `ACL_ADDR_OUT_YL:  rd_data = smp_q.axes.y[`ACL_AX_LO];
      `ACL_ADDR_OUT_YH:  rd_data = {4'h0, smp_q.axes.y[`ACL_AX_HI]};
      `ACL_ADDR_OUT_ZL:  rd_data = smp_q.axes.z[`ACL_AX_LO];
      `ACL_ADDR_OUT_ZH:  rd_data = {4'h0, smp_q.axes.z[`ACL_AX_HI]};
      `ACL_ADDR_VECTOR_MAGNITUDE_REGS_L:  rd_data = smp_q.vector_magnitude_regs[`ACL_AX_LO];
      `ACL_ADDR_VECTOR_MAGNITUDE_REGS_H:  rd_data = {4'h0, smp_q.vector_magnitude_regs[`ACL_AX_HI]};
      `ACL_ADDR_BUF_XL:  rd_data = buf_q.x[`ACL_AX_LO];
      `ACL_ADDR_BUF_XH:  rd_data = {4'h0, buf_q.x[`ACL_AX_HI]};
      `ACL_ADDR_BUF_YL:  rd_data = buf_q.y[`ACL_AX_LO];
      `ACL_ADDR_BUF_YH:  rd_data = {4'h0, buf_q.y[`ACL_AX_HI]};
      `ACL_ADDR_BUF_ZL:  rd_data = buf_q.z[`ACL_AX_LO];
      `ACL_ADDR_BUF_ZH:  rd_data = {4'h0, buf_q.z[`ACL_AX_HI]};
      `ACL_ADDR_CFG1: begin
        rd_data[`ACL_AXIS_RANGE] = axis_sel;
        rd_data[`ACL_PWR_RANGE]  = pwr_mode;
      end
      `ACL_ADDR_ODR:     rd_data[`ACL_ODR_RANGE]   = odr;
      `ACL_ADDR_INT_EN:  rd_data[`ACL_BOOTDIS_BIT] = boot_pulse_disable;
      `ACL_ADDR_PIN_SEL: rd_data[`ACL_BOOTPIN_BIT] = pin_sel;
      `ACL_ADDR_INT_DRV: rd_data[`ACL_OD_BIT]      = od_sel;
      `ACL_ADDR_SELFTEST_IDLE_CODE: rd_data[`ACL_IDLE_RANGE]  = selftest_idle_code;
      `ACL_ADDR_SELFTEST_DECIMATION_CODE:  rd_data[`ACL_DEC_RANGE]   = selftest_decimation_code;
      default: ;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Self-test measurement timing.

  logic        st_on;
  logic [3:0]  dec_eff;
  logic [31:0] phase_tgt;
  logic [31:0] acc_ns;
  logic [11:0] ph_cnt;
  logic [12:0] ph_last;
  logic        ph_done;

  assign st_on     = axis_sel != 2'h0;
  assign dec_eff   = (selftest_decimation_code > `ACL_DEC_MAX) ? `ACL_DEC_MAX : selftest_decimation_code;
  assign phase_tgt = 32'(ST_BASE_NS) + 32'(selftest_idle_code) * 32'(ST_STEP_NS);
  assign ph_last   = (13'h1 << dec_eff) - 13'h1;
  assign ph_done   = acc_ns + 32'(CLK_NS) >= phase_tgt;

  always_ff @(posedge core_clk) begin
    if (rst_int || !st_on) begin
      acc_ns         <= 32'h0;
      ph_cnt         <= 12'h0;
      st_meas_strobe <= 1'b0;
    end else begin
      st_meas_strobe <= 1'b0;
      if (!ph_done) begin
        acc_ns <= acc_ns + 32'(CLK_NS);
      end else begin
        acc_ns <= 32'h0;
        if ({1'b0, ph_cnt} == ph_last) begin
          ph_cnt         <= 12'h0;
          st_meas_strobe <= 1'b1;
        end else begin
          ph_cnt <= ph_cnt + 12'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      selftest_active <= 1'b0;
      meas_odr        <= `ACL_ODR_ST;
      meas_power_mode <= `ACL_PM_LOW;
    end else begin
      selftest_active <= st_on;
      meas_odr        <= st_on ? `ACL_ODR_ST : odr;
      meas_power_mode <= st_on ? `ACL_PM_LOW : pwr_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot sequence.

  acl_boot_e   boot_st;
  logic [31:0] boot_cnt;
  logic        strap_q;
  logic        boot_pls;
  logic        boot_a;
  logic        boot_b;

  assign boot_pls = boot_st == BOOT_PULSE;
  assign boot_a   = boot_pls && !strap_q && !boot_pulse_disable && !pin_sel;
  assign boot_b   = boot_pls && !strap_q && !boot_pulse_disable && pin_sel;

  always_ff @(posedge core_clk) begin
    if (rst_int) strap_q <= 1'b0;
    else strap_q <= sync2[3];
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      boot_st              <= BOOT_WAIT;
      boot_cnt             <= 32'h0;
      load_motion_defaults <= 1'b0;
    end else begin
      load_motion_defaults <= 1'b0;
      unique case (boot_st)
        BOOT_WAIT: begin
          if (boot_cnt == 32'(BOOT_WAIT_CYC - 1)) begin
            boot_st              <= BOOT_PULSE;
            boot_cnt             <= 32'h0;
            load_motion_defaults <= strap_q;
          end else begin
            boot_cnt <= boot_cnt + 32'h1;
          end
        end
        BOOT_PULSE: begin
          if (boot_cnt == 32'(BOOT_PLS_CYC - 1)) boot_st <= BOOT_IDLE;
          else boot_cnt <= boot_cnt + 32'h1;
        end
        BOOT_IDLE: ;
      endcase
    end
  end

  assign boot_done = boot_st == BOOT_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  // Pin drivers and pin events.

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      irq_a_out  <= 1'b0;
      irq_a_oe_n <= 1'b0;
      irq_b_out  <= 1'b0;
      irq_b_oe_n <= 1'b0;
    end else begin
      irq_a_out  <= od_sel ? 1'b0 : (irq_a_req || boot_a);
      irq_a_oe_n <= od_sel ? !(irq_a_req || boot_a) : 1'b0;
      if (strap_q) begin
        irq_b_out  <= 1'b0;
        irq_b_oe_n <= !boot_pls;
      end else begin
        irq_b_out  <= od_sel ? 1'b0 : (irq_b_req || boot_b);
        irq_b_oe_n <= od_sel ? !(irq_b_req || boot_b) : 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_int) begin
      md_out      <= 1'b0;
      md_oe_n     <= 1'b1;
      host_pm_req <= 1'b0;
      single_shot <= 1'b0;
      wake_req    <= 1'b0;
    end else begin
      md_out      <= 1'b0;
      md_oe_n     <= !(strap_q && motion_event);
      host_pm_req <= strap_q && sync2[2];
      single_shot <= sync2[1] && !trig_d;
      wake_req    <= !sync2[0] && cs_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_dec_saturate: assert property (@(posedge core_clk) disable iff (rst_int)
    st_on && selftest_decimation_code > `ACL_DEC_MAX && ph_done && ph_cnt == 12'hfff |=> st_meas_strobe)
    else $error("saturated decimation did not end at 4096 phases");

  a_st_override: assert property (@(posedge core_clk) disable iff (rst_int)
    st_on |=> meas_power_mode == `ACL_PM_LOW && meas_odr == `ACL_ODR_ST)
    else $error("user settings leaked into self-test");

  a_drdy_latch: assert property (@(posedge core_clk) disable iff (rst_int)
    smp_upd |=> drdy && smp_q == $past(smp_upd && sample_valid ? sample : smp_q) || !$past(sample_valid))
    else $error("data ready not set with data load");

  a_trig_shot: assert property (@(posedge core_clk) disable iff (rst_int)
    sync2[1] && !trig_d |=> single_shot ##1 !single_shot)
    else $error("trigger edge did not give one shot");

  a_push_pull: assert property (@(posedge core_clk) disable iff (rst_int)
    !od_sel |=> !irq_a_oe_n) else $error("push-pull pin not driven");

  a_wake_cs: assert property (@(posedge core_clk) disable iff (rst_int)
    !sync2[0] && cs_d |=> wake_req) else $error("chip select did not wake");

  a_md_open_drain: assert property (@(posedge core_clk) disable iff (rst_int)
    strap_q && motion_event |=> !md_oe_n && !md_out)
    else $error("motion pin not pulled low");

  a_boot_pin_a: assert property (@(posedge core_clk) disable iff (rst_int)
    boot_a && !od_sel |=> irq_a_out && !irq_a_oe_n)
    else $error("boot pulse missing on first pin");

  a_boot_od_b: assert property (@(posedge core_clk) disable iff (rst_int)
    strap_q && boot_pls |=> !irq_b_oe_n && !irq_b_out)
    else $error("boot output not pulled low");
endmodule : acl_ctrl

// file: test/acl_host.sv
// Host side of the serial register link: frames, byte exchange, link clock.
// Assumes mode 0 framing and a 12 ns link clock that runs only within frames.
module acl_host (
  output logic      link_clk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic start();
    spi_cs_n = 1'b0;
    #17;
  endtask : start
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = tx[i];
      #6 link_clk = 1'b1;
      // An undriven data line reads back inverted, so a missing drive shows up.
      rx[i] = spi_miso_oe_n ? ~spi_miso : spi_miso;
      #6 link_clk = 1'b0;
    end
  endtask : xbyte
  task automatic stop();
    #7 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #30;
  endtask : stop
endmodule : acl_host

// file: test/tb.sv
// Self-checking bench: registers, coherent data reads, self-test, trigger, boot.
// Assumes the block is built with shortened boot and self-test timing.
`include "acl_map.svh"
module tb import acl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, sys_rst, link_clk, spi_cs_n, spi_mosi, spi_miso;
  logic        sample_valid, buff_valid, external_trigger_in_pin, irq_a_out, irq_a_oe_n;
  logic        single_shot, wake_req, selftest_active, st_meas_strobe, boot_done;
  logic        spi_miso_oe_n, irq_b_out, irq_b_oe_n, md_out, md_oe_n, host_pm_req;
  logic        load_motion_defaults, md_pin_in, strap_pin, motion_event, irq_b_req;
  logic [3:0]  meas_odr;
  logic [1:0]  meas_power_mode;
  logic [7:0]  rb [0:13];
  acl_sample_s sample;
  acl_axes_s   buff;
  int          miscompares, n_checks, cyc, n_wake, n_shot, nfr, n, n_lmd;
  int          dl [3] = '{2, 12, 15};
  acl_ctrl #(.BOOT_WAIT_NS(400), .BOOT_PLS_NS(80), .ST_BASE_NS(4), .ST_STEP_NS(4)) dut (
    .core_clk, .sys_rst, .link_clk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n,
    .sample_valid, .sample, .buff_valid, .buff, .external_trigger_in_pin, .md_pin_in,
    .strap_pin, .motion_event, .irq_a_req(1'b0), .irq_b_req,
    .irq_a_out, .irq_a_oe_n, .irq_b_out, .irq_b_oe_n, .md_out, .md_oe_n,
    .host_pm_req, .single_shot, .wake_req, .selftest_active, .st_meas_strobe,
    .meas_odr, .meas_power_mode, .load_motion_defaults, .boot_done);
  acl_host host (.link_clk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe_n);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (wake_req === 1'b1) n_wake++;
    if (single_shot === 1'b1) n_shot++;
    if (load_motion_defaults === 1'b1) n_lmd++;
    if (cyc == 60000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input int cnt);
    logic [7:0] d;
    nfr++;
    host.start();
    host.xbyte({1'b1, a}, d);
    for (int i = 0; i < cnt; i++) host.xbyte(8'h00, rb[i]);
    host.stop();
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    nfr++;
    host.start();
    host.xbyte({1'b0, a}, x);
    host.xbyte(d, x);
    host.stop();
  endtask : wr
  task automatic step();
    @(posedge core_clk);
    #1;
    n++;
  endtask : step
  task automatic boot();
    n = 0;
    do step(); while (irq_a_out !== 1'b1 && n < 300);
    n = 0;
    while (irq_a_out === 1'b1 && n < 100) step();
    chk(16'(n), 16'd20);
    chk(boot_done, 1'b1);
  endtask : boot
  task automatic wst();
    n = 0;
    do step(); while (st_meas_strobe !== 1'b1 && n < 10000);
  endtask : wst
  task automatic load(input logic [11:0] b);
    step();
    sample = {b, b + 12'h111, b + 12'h222, b + 12'h333};
    buff = {b + 12'h444, b + 12'h555, b + 12'h666};
    sample_valid = 1'b1;
    buff_valid = 1'b1;
    step();
    sample_valid = 1'b0;
    buff_valid = 1'b0;
  endtask : load
  function automatic logic [7:0] eb(input logic [11:0] b, input int j);
    logic [11:0] w;
    w = b + 12'(j / 2) * 12'h111;
    return (j % 2) ? {4'h0, w[11:8]} : w[7:0];
  endfunction : eb
  initial begin
    sys_rst = 1'b1;
    {sample_valid, buff_valid, external_trigger_in_pin, md_pin_in, strap_pin, motion_event, irq_b_req} = 7'h00;
    sample = '0;
    buff = '0;
    repeat (20) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk(irq_a_oe_n, 1'b0);
    boot();
    rd(`ACL_ADDR_SELFTEST_DECIMATION_CODE, 1);
    chk(rb[0], 8'h00);
    wr(`ACL_ADDR_SELFTEST_DECIMATION_CODE, 8'h0d);
    rd(`ACL_ADDR_SELFTEST_DECIMATION_CODE, 1);
    chk(rb[0], 8'h0d);
    rd(7'h30, 1);
    chk(rb[0], 8'h00);
    $display("register test done");
    wr(`ACL_ADDR_ODR, 8'h05);
    wr(`ACL_ADDR_CFG1, 8'h02);
    wr(`ACL_ADDR_SELFTEST_IDLE_CODE, 8'h01);
    chk({meas_odr, meas_power_mode}, {4'h5, 2'h2});
    foreach (dl[k]) begin
      wr(`ACL_ADDR_SELFTEST_DECIMATION_CODE, 8'(dl[k]));
      wr(`ACL_ADDR_CFG1, 8'h22);
      chk({meas_odr, meas_power_mode, selftest_active}, 7'h01);
      wst();
      wst();
      chk(16'(n), 16'((1 << (dl[k] > 12 ? 12 : dl[k])) * 2));
      wr(`ACL_ADDR_CFG1, 8'h02);
      chk({meas_odr, meas_power_mode, selftest_active}, {4'h5, 2'h2, 1'b0});
    end
    $display("self-test test done");
    load(12'h123);
    rd(`ACL_ADDR_STATUS, 1);
    chk(rb[0][7], 1'b1);
    fork
      rd(`ACL_ADDR_OUT_XL, 14);
      begin
        repeat (40) @(posedge core_clk);
        load(12'h9a1);
      end
    join
    for (int j = 0; j < 14; j++) chk(rb[j], eb(12'h123, j));
    rd(`ACL_ADDR_OUT_XL, 14);
    for (int j = 0; j < 14; j++) chk(rb[j], eb(12'h9a1, j));
    $display("data test done");
    step();
    external_trigger_in_pin = 1'b1;
    repeat (10) step();
    external_trigger_in_pin = 1'b0;
    repeat (10) step();
    chk(16'(n_shot), 16'd1);
    chk(16'(n_wake), 16'(nfr));
    $display("trigger test done");
    {irq_b_req, md_pin_in, motion_event} = 3'b111;
    repeat (4) step();
    chk({md_oe_n, host_pm_req, irq_b_out, irq_b_oe_n}, 4'b1010);
    wr(`ACL_ADDR_INT_DRV, 8'h01);
    chk({irq_a_out, irq_a_oe_n, irq_b_out, irq_b_oe_n}, 4'b0100);
    step();
    {irq_b_req, md_pin_in, motion_event} = 3'b000;
    repeat (4) step();
    chk({irq_b_out, irq_b_oe_n}, 2'b01);
    $display("pin drive test done");
    wr(`ACL_ADDR_CFG1, 8'h80);
    boot();
    rd(`ACL_ADDR_SELFTEST_DECIMATION_CODE, 1);
    chk(rb[0], 8'h00);
    $display("soft reset test done");
    step();
    strap_pin = 1'b1;
    repeat (4) step();
    wr(`ACL_ADDR_CFG1, 8'h80);
    n = 0;
    do step(); while (irq_b_oe_n !== 1'b0 && n < 300);
    chk({irq_a_out, irq_b_out}, 2'b00);
    n = 0;
    while (irq_b_oe_n === 1'b0 && n < 100) step();
    chk(16'(n), 16'd20);
    chk(16'(n_lmd), 16'd1);
    wr(`ACL_ADDR_CFG1, 8'h00);
    step();
    {md_pin_in, motion_event} = 2'b11;
    repeat (4) step();
    chk({md_oe_n, md_out, host_pm_req, meas_power_mode}, 5'b00100);
    $display("strap test done");
    stop_test();
  end
endmodule : tb
